// ==== rtl/dmr_regs.sv ====
`timescale 1ns/10ps
// How it works
// - Stop oscillator only when run-time setting zero.
// - Report read-only 3-bit maximum activate count.
// - Bit 3 flags unlimited activates.
// - Unlimited flag forces count field to zero.
// - Write-only refresh bank and enable, enable resets off.
// - Repair register shows one available bit per bank.
// - Test register writes ignored, normal timing kept.
// - Pattern A resets to 5AH, writable.
// - Calibration sends A then B, LSB first.
// - ECC enable bit, resets enabled.
// - Error pad enable bit, resets off.
// - Pad output needs ECC enabled too.
// - Writing clear bit clears event record.
// - Clear self-clears, resets both flags.
// - Double-bit error sets its flag.
// - Any ECC event sets event flag.
// - Flags stay set until cleared.
// - Eight-bit event counter, zero without events.
// - Counter saturates at full scale.
// - Clear also zeroes the counter.
module dmr_regs #(
   parameter logic [6:0] READ_CAL_OPCODE = 7'h43
) (
   input  wire logic                              core_clk,
   input  wire logic                              link_clk,
   input  wire logic                              reset_n,
   input  wire logic                              mrw_valid,
   input  wire logic [dmr_pkg::MR_ADDR_W-1:0]     mrw_addr,
   input  wire logic [dmr_pkg::MR_DATA_W-1:0]     mrw_data,
   input  wire logic                              mrr_valid,
   input  wire logic [dmr_pkg::MR_ADDR_W-1:0]     mrr_addr,
   output logic      [dmr_pkg::MR_DATA_W-1:0]     mrr_data,
   output logic                                   mrr_data_valid,
   input  wire logic                              mpc_valid,
   input  wire logic [dmr_pkg::MPC_OP_W-1:0]      mpc_opcode,
   input  wire logic [dmr_pkg::MR_DATA_W-1:0]     interval_timer_runtime_reg,
   input  wire logic [dmr_pkg::MR_DATA_W-1:0]     read_calibration_pattern_b,
   input  wire logic [2:0]                        max_activate_count,
   input  wire logic                              activate_limit_unbounded,
   input  wire logic [dmr_pkg::MR_DATA_W-1:0]     repair_resource_available,
   input  wire logic                              ecc_correct_event,
   input  wire logic                              ecc_double_error,
   output logic                                   osc_stop,
   output logic                                   targeted_refresh_enable,
   output logic      [2:0]                        targeted_refresh_bank,
   output logic                                   ecc_enable,
   output logic                                   error_pad,
   output logic                                   cal_busy,
   output logic                                   cal_dq,
   output logic                                   cal_dq_valid
);
   import dmr_pkg::*;

   // ************************************************************
   // Address decode
   // ************************************************************

   // Matches a command strobe against one mode-register address.
   function automatic logic dmr_hit(input logic v, input logic [5:0] a, input logic [5:0] t);
      dmr_hit = v && (a == t);
   endfunction

   logic [7:0]           cal_a_reg;
   logic                 ecc_en_reg;
   logic                 pad_en_reg;
   logic                 dbl_flag_reg;
   logic                 evt_flag_reg;
   logic [7:0]           count_reg;
   logic                 tr_en_reg;
   logic [2:0]           tr_bank_reg;
   logic [7:0]           mrr_data_reg;
   logic                 mrr_valid_reg;
   logic                 osc_stop_reg;
   logic                 error_pad_reg;
   logic                 cal_busy_reg;
   logic                 cal_req_tog_reg;
   logic [CAL_LEN-1:0]   cal_snap_reg;
   logic                 done_s1_reg;
   logic                 done_s2_reg;
   logic                 done_s3_reg;
   logic                 done_filt_reg;
   logic                 done_seen_reg;

   wire wr_act   = dmr_hit(mrw_valid, mrw_addr, ADDR_ACT_LIMIT);
   wire wr_test  = dmr_hit(mrw_valid, mrw_addr, ADDR_TEST);
   wire wr_cal_a = dmr_hit(mrw_valid, mrw_addr, ADDR_CAL_A);
   wire wr_ecc   = dmr_hit(mrw_valid, mrw_addr, ADDR_ECC_CTRL);

   // ************************************************************
   // ECC event record
   // ************************************************************

   // Events are gated by the ECC enable; a double error is also an event.
   wire clear_wr      = wr_ecc && mrw_data[CLEAR_BIT];
   wire dbl_in        = ecc_en_reg && ecc_double_error;
   wire evt_any       = ecc_en_reg && (ecc_correct_event || ecc_double_error);
   wire pad_live      = ecc_en_reg && pad_en_reg;
   wire count_full    = (count_reg == COUNT_MAX);

   // Set wins over clear, so an event in the clear cycle is kept.
   wire dbl_flag_next = dbl_in ? 1'h1 : (clear_wr ? 1'h0 : dbl_flag_reg);
   wire evt_flag_next = evt_any ? 1'h1 : (clear_wr ? 1'h0 : evt_flag_reg);
   wire [7:0] count_base = clear_wr ? COUNT_ZERO : count_reg;
   wire [7:0] count_next = (evt_any && (clear_wr || !count_full)) ?
                           count_base + 8'h01 : count_base;

   // ************************************************************
   // Command decode
   // ************************************************************

   // Stop is honoured only while the interval timer runs in manual mode.
   wire stop_cmd_legal = mpc_valid && (mpc_opcode == MPC_STOP_OSC) &&
                         (interval_timer_runtime_reg == RUNTIME_MANUAL);
   wire cal_start      = mpc_valid && (mpc_opcode == READ_CAL_OPCODE) && !cal_busy_reg;
   wire done_evt       = done_filt_reg ^ done_seen_reg;

   // ************************************************************
   // Read data selection
   // ************************************************************

   // Write-only fields and unmapped addresses read as zero.
   wire [7:0] rd_act   = {4'h0, activate_limit_unbounded,
                          activate_limit_unbounded ? 3'h0 : max_activate_count};
   wire [7:0] rd_ecc   = {ecc_en_reg, pad_en_reg, 4'h0, dbl_flag_reg, evt_flag_reg};
   wire [7:0] mrr_next =
      dmr_hit(mrr_valid, mrr_addr, ADDR_ACT_LIMIT) ? rd_act :
      dmr_hit(mrr_valid, mrr_addr, ADDR_REPAIR)    ? repair_resource_available :
      dmr_hit(mrr_valid, mrr_addr, ADDR_ECC_CTRL)  ? rd_ecc :
      dmr_hit(mrr_valid, mrr_addr, ADDR_ECC_COUNT) ? count_reg : 8'h00;

   // ************************************************************
   // Mode-register state
   // ************************************************************

   // Writable fields; the test register has no storage at all.
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         cal_a_reg   <= CAL_A_RESET;
         ecc_en_reg  <= ECC_EN_RESET;
         pad_en_reg  <= PAD_EN_RESET;
         tr_en_reg   <= TR_EN_RESET;
         tr_bank_reg <= TR_BANK_RESET;
      end else begin
         if (wr_cal_a) begin
            cal_a_reg <= mrw_data;
         end
         if (wr_ecc) begin
            ecc_en_reg <= mrw_data[ECC_EN_BIT];
            pad_en_reg <= mrw_data[PAD_EN_BIT];
         end
         if (wr_act) begin
            tr_en_reg   <= mrw_data[TR_ENABLE_BIT];
            tr_bank_reg <= mrw_data[TR_BANK_MSB:TR_BANK_LSB];
         end
      end
   end

   // Event record, read port and command pulses.
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         dbl_flag_reg  <= 1'h0;
         evt_flag_reg  <= 1'h0;
         count_reg     <= COUNT_ZERO;
         mrr_data_reg  <= 8'h00;
         mrr_valid_reg <= 1'h0;
         osc_stop_reg  <= 1'h0;
         error_pad_reg <= 1'h0;
      end else begin
         dbl_flag_reg  <= dbl_flag_next;
         evt_flag_reg  <= evt_flag_next;
         count_reg     <= count_next;
         mrr_data_reg  <= mrr_next;
         mrr_valid_reg <= mrr_valid;
         osc_stop_reg  <= stop_cmd_legal;
         error_pad_reg <= pad_live && evt_any;
      end
   end

   // ************************************************************
   // Calibration request, core side
   // ************************************************************

   // The snapshot holds still until the link side reports done.
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         cal_busy_reg    <= 1'h0;
         cal_req_tog_reg <= 1'h0;
         cal_snap_reg    <= '0;
         done_filt_reg   <= 1'h0;
         done_seen_reg   <= 1'h0;
      end else begin
         if (cal_start) begin
            cal_busy_reg    <= 1'h1;
            cal_req_tog_reg <= ~cal_req_tog_reg;
            cal_snap_reg    <= {read_calibration_pattern_b, cal_a_reg};
         end else if (done_evt) begin
            cal_busy_reg <= 1'h0;
         end
         if (done_s2_reg == done_s3_reg) begin
            done_filt_reg <= done_s3_reg;
         end
         done_seen_reg <= done_filt_reg;
      end
   end

   // ************************************************************
   // Link clock domain
   // ************************************************************

   logic                 lrst_s1_reg;
   logic                 lrst_s2_reg;
   logic                 lrst_s3_reg;
   logic                 req_s1_reg;
   logic                 req_s2_reg;
   logic                 req_s3_reg;
   logic                 req_filt_reg;
   logic                 req_seen_reg;
   logic                 done_tog_reg;
   logic [CAL_LEN-1:0]   shift_reg;
   logic [CAL_CNT_W-1:0] bit_cnt_reg;
   logic                 cal_dq_reg;
   logic                 cal_dq_valid_reg;
   dmr_link_state_t      link_state_reg;

   wire link_rst_n = lrst_s3_reg;
   wire req_evt    = req_filt_reg ^ req_seen_reg;

   // Synchronisers toward the link clock, including its reset.
   always_ff @(posedge link_clk) begin
      lrst_s1_reg <= reset_n;
      lrst_s2_reg <= lrst_s1_reg;
      lrst_s3_reg <= lrst_s2_reg;
      req_s1_reg  <= cal_req_tog_reg;
      req_s2_reg  <= req_s1_reg;
      req_s3_reg  <= req_s2_reg;
   end

   // Done toggle back toward the core clock.
   always_ff @(posedge core_clk) begin
      done_s1_reg <= done_tog_reg;
      done_s2_reg <= done_s1_reg;
      done_s3_reg <= done_s2_reg;
   end

   // Serializer: sixteen bits, pattern A then B, low bit first.
   always_ff @(posedge link_clk) begin
      if (!link_rst_n) begin
         req_filt_reg     <= 1'h0;
         req_seen_reg     <= 1'h0;
         done_tog_reg     <= 1'h0;
         shift_reg        <= '0;
         bit_cnt_reg      <= '0;
         cal_dq_reg       <= 1'h0;
         cal_dq_valid_reg <= 1'h0;
         link_state_reg   <= DMR_LINK_IDLE;
      end else begin
         if (req_s2_reg == req_s3_reg) begin
            req_filt_reg <= req_s3_reg;
         end
         req_seen_reg <= req_filt_reg;
         case (link_state_reg)
            DMR_LINK_IDLE: begin
               cal_dq_valid_reg <= 1'h0;
               if (req_evt) begin
                  shift_reg      <= cal_snap_reg;
                  bit_cnt_reg    <= '0;
                  link_state_reg <= DMR_LINK_SHIFT;
               end
            end
            DMR_LINK_SHIFT: begin
               cal_dq_reg       <= shift_reg[0];
               cal_dq_valid_reg <= 1'h1;
               shift_reg        <= shift_reg >> 1;
               bit_cnt_reg      <= bit_cnt_reg + 4'h1;
               if (bit_cnt_reg == CAL_LAST) begin
                  link_state_reg <= DMR_LINK_DONE;
               end
            end
            DMR_LINK_DONE: begin
               cal_dq_valid_reg <= 1'h0;
               done_tog_reg     <= ~done_tog_reg;
               link_state_reg   <= DMR_LINK_IDLE;
            end
            default: begin
               cal_dq_valid_reg <= 1'h0;
               link_state_reg   <= DMR_LINK_IDLE;
            end
         endcase
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************

   // Every output is a flip-flop.
   assign mrr_data                = mrr_data_reg;
   assign mrr_data_valid          = mrr_valid_reg;
   assign osc_stop                = osc_stop_reg;
   assign targeted_refresh_enable = tr_en_reg;
   assign targeted_refresh_bank   = tr_bank_reg;
   assign ecc_enable              = ecc_en_reg;
   assign error_pad               = error_pad_reg;
   assign cal_busy                = cal_busy_reg;
   assign cal_dq                  = cal_dq_reg;
   assign cal_dq_valid            = cal_dq_valid_reg;

   // ************************************************************
   // Assertions
   // ************************************************************

   // A calibration frame is sixteen valid bits followed by a gap.
   sequence seq_cal_frame;
      cal_dq_valid_reg[*8] ##1 cal_dq_valid_reg[*8] ##1 !cal_dq_valid_reg;
   endsequence

   a_osc_stop_cause: assert property (@(posedge core_clk) disable iff (!reset_n)
      osc_stop_reg == $past(stop_cmd_legal))
      else $error("Oscillator stop does not follow a legal stop command.");

   a_act_unbounded: assert property (@(posedge core_clk) disable iff (!reset_n)
      dmr_hit(mrr_valid, mrr_addr, ADDR_ACT_LIMIT) && activate_limit_unbounded
      |=> mrr_valid_reg && mrr_data_reg[ACT_UNBOUND_BIT] && (mrr_data_reg[ACT_COUNT_MSB:0] == 3'h0))
      else $error("Unlimited activate readout is not zero count with flag set.");

   a_repair_read: assert property (@(posedge core_clk) disable iff (!reset_n)
      dmr_hit(mrr_valid, mrr_addr, ADDR_REPAIR) |=> mrr_data_reg == $past(repair_resource_available))
      else $error("Repair readout differs from the per-bank resource bits.");

   a_test_ignored: assert property (@(posedge core_clk) disable iff (!reset_n)
      wr_test |=> (cal_a_reg == $past(cal_a_reg)) && (ecc_en_reg == $past(ecc_en_reg)) &&
                  (tr_en_reg == $past(tr_en_reg)))
      else $error("Test register write changed device state.");

   a_reset_values: assert property (@(posedge core_clk) disable iff (!reset_n)
      $rose(reset_n) |-> (cal_a_reg == CAL_A_RESET) && ecc_en_reg && !pad_en_reg && !tr_en_reg)
      else $error("Register reset values are wrong.");

   a_pad_gated: assert property (@(posedge core_clk) disable iff (!reset_n)
      error_pad_reg |-> $past(pad_live) && $past(evt_any))
      else $error("Error pad driven without both enables and an event.");

   a_clear_all: assert property (@(posedge core_clk) disable iff (!reset_n)
      clear_wr && !evt_any |=> !evt_flag_reg && !dbl_flag_reg && (count_reg == COUNT_ZERO))
      else $error("Clear write did not empty the event record.");

   a_flag_sticky: assert property (@(posedge core_clk) disable iff (!reset_n)
      (evt_flag_reg || dbl_flag_reg) && !clear_wr
      |=> (evt_flag_reg >= $past(evt_flag_reg)) && (dbl_flag_reg >= $past(dbl_flag_reg)))
      else $error("Event flag dropped without a clear.");

   a_double_set: assert property (@(posedge core_clk) disable iff (!reset_n)
      dbl_in |=> dbl_flag_reg && evt_flag_reg)
      else $error("Double error did not set its flags.");

   a_count_sat: assert property (@(posedge core_clk) disable iff (!reset_n)
      count_full && !clear_wr |=> count_reg == COUNT_MAX)
      else $error("Event counter wrapped past full scale.");

   a_event_pair: assert property (@(posedge core_clk) disable iff (!reset_n)
      evt_any && !clear_wr && !count_full |=> evt_flag_reg && (count_reg == $past(count_reg) + 8'h01))
      else $error("Event did not set flag and count together.");

   a_cal_frame: assert property (@(posedge link_clk) disable iff (!link_rst_n)
      $rose(cal_dq_valid_reg) |-> seq_cal_frame)
      else $error("Calibration frame is not sixteen bits long.");

   a_cal_first_bit: assert property (@(posedge link_clk) disable iff (!link_rst_n)
      $rose(cal_dq_valid_reg) |-> cal_dq_reg == cal_snap_reg[0])
      else $error("Calibration frame does not start with pattern A low bit.");

endmodule

// ==== rtl/dmr_pkg.sv ====
package dmr_pkg;

   // ************************************************************
   // Mode-register addresses and widths
   // ************************************************************
   localparam int              MR_ADDR_W        = 6;
   localparam int              MR_DATA_W        = 8;
   localparam int              MPC_OP_W         = 7;
   localparam logic [5:0]      ADDR_ACT_LIMIT   = 6'h18;
   localparam logic [5:0]      ADDR_REPAIR      = 6'h19;
   localparam logic [5:0]      ADDR_TEST        = 6'h1E;
   localparam logic [5:0]      ADDR_CAL_A       = 6'h20;
   localparam logic [5:0]      ADDR_ECC_CTRL    = 6'h21;
   localparam logic [5:0]      ADDR_ECC_COUNT   = 6'h22;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int              ACT_COUNT_MSB    = 2;
   localparam int              ACT_UNBOUND_BIT  = 3;
   localparam int              TR_BANK_LSB      = 4;
   localparam int              TR_BANK_MSB      = 6;
   localparam int              TR_ENABLE_BIT    = 7;
   localparam int              ECC_EN_BIT       = 7;
   localparam int              PAD_EN_BIT       = 6;
   localparam int              CLEAR_BIT        = 5;

   // ************************************************************
   // Reset values and codes
   // ************************************************************
   localparam logic [7:0]      CAL_A_RESET      = 8'h5A;
   localparam logic            ECC_EN_RESET     = 1'h1;
   localparam logic            PAD_EN_RESET     = 1'h0;
   localparam logic            TR_EN_RESET      = 1'h0;
   localparam logic [2:0]      TR_BANK_RESET    = 3'h0;
   localparam logic [7:0]      COUNT_MAX        = 8'hFF;
   localparam logic [7:0]      COUNT_ZERO       = 8'h00;
   localparam logic [7:0]      RUNTIME_MANUAL   = 8'h00;
   localparam logic [6:0]      MPC_STOP_OSC     = 7'h4D;

   // ************************************************************
   // Calibration serializer
   // ************************************************************
   localparam int              CAL_LEN          = 16;
   localparam int              CAL_CNT_W        = 4;
   localparam logic [3:0]      CAL_LAST         = 4'hF;

   typedef enum logic [1:0] {
      DMR_LINK_IDLE  = 2'h0,
      DMR_LINK_SHIFT = 2'h1,
      DMR_LINK_DONE  = 2'h3
   } dmr_link_state_t;

endpackage

// ==== bench/dmr_cal_rx.sv ====
`timescale 1ns/10ps
// ****************************************
// Calibration link receiver
// ****************************************
module dmr_cal_rx (
   input  wire logic        link_clk,
   input  wire logic        cal_dq,
   input  wire logic        cal_dq_valid,
   output logic      [15:0] cal_word,
   output int unsigned      cal_bits
);
   initial cal_bits = 0;
   // Shifts in from the top, so the first bit received ends in bit 0.
   always @(posedge link_clk) begin
      if (cal_dq_valid === 1'b1) begin
         cal_word <= {cal_dq, cal_word[15:1]};
         cal_bits <= cal_bits + 1;
      end
   end
endmodule

// ==== bench/dmr_regs_tb.sv ====
`timescale 1ns/10ps
module dmr_regs_tb;
   import dmr_pkg::*;
   logic        core_clk, link_clk, reset_n, mrw_valid, mrr_valid, mpc_valid, ev, dbl, unb;
   logic        mrr_data_valid, osc_stop, tr_en, ecc_en, err_pad, cal_busy, cal_dq, cal_dq_valid;
   logic [5:0]  mrw_addr, mrr_addr;
   logic [7:0]  mrw_data, mrr_data, runtime, pat_b, repair;
   logic [6:0]  mpc_op;
   logic [2:0]  mac, tr_bank;
   logic [15:0] cal_word;
   int unsigned cal_bits;
   int          error_cnt = 0;
   int          tests_run = 0;
   // Core clock at 4 ns and an unrelated link clock at 6 ns.
   initial begin
      core_clk = 0;
      forever #2 core_clk = ~core_clk;
   end
   initial begin
      link_clk = 0;
      #1.3;
      forever #3 link_clk = ~link_clk;
   end
   dmr_regs i_dut (.core_clk, .link_clk, .reset_n, .mrw_valid, .mrw_addr, .mrw_data, .mrr_valid, .mrr_addr,
      .mrr_data, .mrr_data_valid, .mpc_valid, .mpc_opcode(mpc_op), .interval_timer_runtime_reg(runtime),
      .read_calibration_pattern_b(pat_b), .max_activate_count(mac), .activate_limit_unbounded(unb),
      .repair_resource_available(repair), .ecc_correct_event(ev), .ecc_double_error(dbl), .osc_stop,
      .targeted_refresh_enable(tr_en), .targeted_refresh_bank(tr_bank), .ecc_enable(ecc_en),
      .error_pad(err_pad), .cal_busy, .cal_dq, .cal_dq_valid);
   dmr_cal_rx i_rx (.link_clk, .cal_dq, .cal_dq_valid, .cal_word, .cal_bits);
   task summarize;
      $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task chk(input logic ok, input string msg);
      tests_run++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask
   task tick;
      @(posedge core_clk);
      #1;
   endtask
   task mrw(input logic [5:0] a, input logic [7:0] d);
      mrw_valid = 1;
      mrw_addr = a;
      mrw_data = d;
      tick;
      mrw_valid = 0;
      tick;
   endtask
   task mrr(input logic [5:0] a, input logic [7:0] exp);
      mrr_valid = 1;
      mrr_addr = a;
      tick;
      mrr_valid = 0;
      chk(mrr_data_valid === 1'b1 && mrr_data === exp, $sformatf("read %h got %h", a, mrr_data));
      tick;
   endtask
   task mpc(input logic [6:0] op);
      mpc_valid = 1;
      mpc_op = op;
      tick;
      mpc_valid = 0;
   endtask
   task evt(input logic d, input logic pad);
      ev = 1;
      dbl = d;
      tick;
      ev = 0;
      dbl = 0;
      chk(err_pad === pad, "error pad");
      tick;
   endtask
   task t_reset;
      mrr(6'h21, 8'h80);
      mrr(6'h22, 8'h00);
      mrr(6'h20, 8'h00);
      mrr(6'h3F, 8'h00);
      chk(tr_en === 1'b0 && ecc_en === 1'b1 && err_pad === 1'b0, "reset levels");
   endtask
   task t_act;
      mac = 3'h5;
      mrr(6'h18, 8'h05);
      unb = 1;
      mrr(6'h18, 8'h08);
      mrw(6'h18, 8'hD7);
      chk(tr_en === 1'b1 && tr_bank === 3'h5, "refresh bank");
      mrr(6'h18, 8'h08);
   endtask
   task t_misc;
      repair = 8'hA5;
      mrr(6'h19, 8'hA5);
      mrw(6'h19, 8'h00);
      mrw(6'h1E, 8'hFF);
      mrr(6'h19, 8'hA5);
      mrr(6'h21, 8'h80);
      mrr(6'h1E, 8'h00);
   endtask
   task t_osc;
      mpc(MPC_STOP_OSC);
      chk(osc_stop === 1'b1, "stop pulse");
      tick;
      chk(osc_stop === 1'b0, "stop pulse end");
      runtime = 8'h01;
      mpc(MPC_STOP_OSC);
      chk(osc_stop === 1'b0, "stop refused");
      tick;
      runtime = 8'h00;
   endtask
   task t_ecc;
      evt(0, 0);
      mrr(6'h21, 8'h81);
      mrr(6'h22, 8'h01);
      mrw(6'h21, 8'hC0);
      evt(1, 1);
      mrr(6'h21, 8'hC3);
      mrr(6'h22, 8'h02);
      mrw(6'h21, 8'hE0);
      mrr(6'h21, 8'hC0);
      mrr(6'h22, 8'h00);
      mrw(6'h21, 8'h40);
      chk(ecc_en === 1'b0, "ecc off");
      evt(0, 0);
      mrr(6'h22, 8'h00);
      mrw(6'h21, 8'h80);
      ev = 1;
      repeat (260) tick;
      ev = 0;
      mrr(6'h22, 8'hFF);
      ev = 1;
      mrw_valid = 1;
      mrw_addr = 6'h21;
      mrw_data = 8'hA0;
      tick;
      ev = 0;
      mrw_valid = 0;
      tick;
      mrr(6'h22, 8'h01);
      mrr(6'h21, 8'h81);
   endtask
   task t_cal;
      int unsigned n;
      int          i;
      for (int k = 0; k < 2; k++) begin
         if (k == 1) mrw(6'h20, 8'h27);
         n = cal_bits;
         mpc(7'h43);
         chk(cal_busy === 1'b1, "cal busy");
         for (i = 0; i < 400 && cal_busy !== 1'b0; i++) tick;
         if (i == 400) begin
            chk(1'b0, "cal timeout");
            summarize;
         end
         repeat (3) tick;
         chk(cal_bits == n + 16 && cal_word === {pat_b, (k == 1) ? 8'h27 : CAL_A_RESET}, "cal frame");
         tick;
      end
   endtask
   // Main sequence: inputs change 1 ns after the core clock edge.
   initial begin
      {reset_n, mrw_valid, mrr_valid, mpc_valid, ev, dbl, unb} = '0;
      {mrw_addr, mrr_addr, mrw_data, runtime, repair, mpc_op, mac} = '0;
      pat_b = 8'h3C;
      repeat (8) @(posedge core_clk);
      #1 reset_n = 1;
      t_reset;
      t_act;
      t_misc;
      t_osc;
      t_ecc;
      t_cal;
      summarize;
   end
endmodule
